// ### tmr8_pkg.sv
// Functional notes
// - timer halts while the power-reduce bit is one; clear it to run.
// - count, compare A and compare B registers are all 8 bits wide.
// - all request sources are flags in one register, each masked by its own bit.
// - tick source is the I/O clock, or the oscillator pin when async select is one.
// - async select resets to zero, so the I/O clock is the default source.
// - clock-select code zero produces no tick; the counter stays stopped.
// - both buffered compare values are compared with the count on every timer tick.
// - a match on channel A or B sets that channel's flag; mask gates its request.
// - bottom indication at count 0x00, maximum indication at count 0xff.
// - top is 0xff or compare A, depending on waveform mode.
// - each tick clears, increments or decrements the count per mode and direction.
// - software reads and writes the count at any time, ticking or not.
// - a software count write beats any clear or count in the same cycle.
// - waveform mode is three bits: two low in control A, high bit in control B.
// - overflow flag sets at a mode-dependent point and requests when unmasked.
// - top and bottom indications steer direction and clear control.
// - mode 0 counts up, wraps 0xff to 0x00, overflow set as count becomes zero.
// - mode 2 clears the count when it equals compare A, which acts as top.
// - fast pwm top is 0xff in mode 3 and compare A in mode 7.
// - modes 1 and 5 count up to top, then down to bottom; overflow at bottom.
package tmr8_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int PRE_W = 10;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ASYNC = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_POWER = 6'h20;
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int NFLAG = 3;
  localparam int CTRLB_WGM2 = 3;
  localparam int ASYNC_SEL_BIT = 5;
  localparam int POWER_BIT = 0;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  // prescaler tap widths per clock-select code: /1 /8 /32 /64 /128 /256 /1024
  localparam logic [3:0] TAP_BITS [8] = '{4'h0, 4'h0, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha};
  typedef enum logic {TMR8_BUS_IDLE, TMR8_BUS_ACK} tmr8_bus_t;
endpackage : tmr8_pkg

// ### tmr8_prescaler.sv
`timescale 1ns/1ps
module tmr8_prescaler
  import tmr8_pkg::*;
#(
  parameter int W = PRE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic enable,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  logic [W-1:0] pcnt;
  logic [W-1:0] next_pcnt;
  logic [W-1:0] tap_mask;

  always_comb begin
    next_pcnt = pcnt;
    // prescaler halts with the timer while power reduce is set
    if (src_tick && enable) begin
      next_pcnt = W'(pcnt + 1'b1);
    end
    tap_mask = W'((11'h1 << TAP_BITS[clk_sel]) - 11'h1);
    // code zero stops, code one passes every source edge
    tick = enable && (clk_sel != CS_STOP) && src_tick && (&(pcnt | ~tap_mask));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt <= '0;
    end else begin
      pcnt <= next_pcnt;
    end
  end
endmodule : tmr8_prescaler

// ### tmr8_tb.sv
`timescale 1ns/1ps
module tb;
  import tmr8_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [DATA_W-1:0] avs_readdata;
  logic [DATA_W-1:0] rd;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest;
  logic osc_pin_in;
  logic [2:0] int_ack;
  logic [2:0] irq;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic top_q;
  int n_fail;
  int comparisons;

  tmr8_timer tmr8_timer_i (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .OSC_PIN_IN(osc_pin_in),
    .INT_ACK_OVF(int_ack[0]), .INT_ACK_CMPA(int_ack[1]), .INT_ACK_CMPB(int_ack[2]),
    .IRQ_OVF(irq[0]), .IRQ_CMPA(irq[1]), .IRQ_CMPB(irq[2]), .COUNT_AT_BOTTOM(at_bottom),
    .COUNT_AT_MAX(at_max), .COUNT_AT_TOP(at_top)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) top_q <= at_top;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // holds the request until waitrequest is sampled low, then releases
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) chk(32'(avs_waitrequest), 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // cycles until the next rising edge of the top indication
  task automatic rise(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (!(at_top === 1'b1 && top_q === 1'b0) && k < 2100);
  endtask : rise

  task automatic t_reset;
    chk(32'(at_bottom), 32'h1);
    chk(32'(at_max), 32'h0);
    chk(32'(irq), 32'h0);
    rdchk(OFS_CTRL_B, 32'h0);
    rdchk(OFS_ASYNC, 32'h0);
    rdchk(OFS_COUNT, 32'h0);
    rdchk(OFS_POWER, 32'h0);
    rdchk(6'h3c, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_stop;
    wr(OFS_COUNT, 32'h1ab);
    cyc(10);
    rdchk(OFS_COUNT, 32'hab);
    avs_byteenable <= 4'he;
    wr(OFS_COUNT, 32'h11);
    avs_byteenable <= 4'hf;
    rdchk(OFS_COUNT, 32'hab);
    wr(OFS_COUNT, 32'hff);
    cyc(2);
    chk(32'(at_max), 32'h1);
    chk(32'(at_bottom), 32'h0);
    $display("test stop done");
  endtask : t_stop

  task automatic t_power;
    wr(OFS_POWER, 32'h1);
    wr(OFS_COUNT, 32'h20);
    wr(OFS_CTRL_B, 32'h1);
    cyc(10);
    rdchk(OFS_COUNT, 32'h20);
    wr(OFS_POWER, 32'h0);
    cyc(5);
    wr(OFS_CTRL_B, 32'h0);
    xfer(1'b0, OFS_COUNT, 32'h0, rd);
    chk(32'(rd[7:0] != 8'h20), 32'h1);
    $display("test power done");
  endtask : t_power

  task automatic t_prio;
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CTRL_B, 32'h1);
    wr(OFS_COUNT, 32'h80);
    wr(OFS_CTRL_B, 32'h0);
    xfer(1'b0, OFS_COUNT, 32'h0, rd);
    chk(rd, 32'h83);
    $display("test priority done");
  endtask : t_prio

  task automatic t_modes;
    logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
    int per [6] = '{256, 510, 5, 256, 8, 5};
    logic [2:0] fl [6] = '{3'h7, 3'h7, 3'h6, 3'h7, 3'h7, 3'h7};
    int k;
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_CMP_A, 32'h4);
      wr(OFS_CMP_B, 32'h2);
      wr(OFS_CTRL_A, 32'(md[i][1:0]));
      wr(OFS_COUNT, 32'h0);
      wr(OFS_FLAG, 32'h7);
      wr(OFS_CTRL_B, 32'({md[i][2], 3'h1}));
      rise(k);
      rise(k);
      rise(k);
      chk(32'(k), 32'(per[i]));
      wr(OFS_CTRL_B, 32'h0);
      rdchk(OFS_FLAG, 32'(fl[i]));
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_irq;
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CMP_A, 32'h4);
    wr(OFS_CMP_B, 32'h2);
    wr(OFS_COUNT, 32'hf0);
    wr(OFS_FLAG, 32'h7);
    wr(OFS_CTRL_B, 32'h1);
    cyc(40);
    wr(OFS_CTRL_B, 32'h0);
    chk(32'(irq), 32'h0);
    rdchk(OFS_FLAG, 32'h7);
    wr(OFS_MASK, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h1);
    wr(OFS_MASK, 32'h7);
    cyc(2);
    chk(32'(irq), 32'h7);
    int_ack <= 3'h1;
    @(posedge sys_clk);
    int_ack <= 3'h0;
    cyc(2);
    chk(32'(irq), 32'h6);
    wr(OFS_FLAG, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h4);
    rdchk(OFS_FLAG, 32'h4);
    wr(OFS_MASK, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_async;
    wr(OFS_ASYNC, 32'h20);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL_B, 32'h1);
    cyc(10);
    rdchk(OFS_COUNT, 32'h0);
    repeat (5) begin
      osc_pin_in <= 1'b1;
      cyc(4);
      osc_pin_in <= 1'b0;
      cyc(4);
    end
    cyc(6);
    rdchk(OFS_COUNT, 32'h5);
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_ASYNC, 32'h0);
    $display("test async done");
  endtask : t_async

  // ctc with top one: two ticks per period, each tick one divisor of cycles
  task automatic t_presc;
    int per [6] = '{16, 64, 128, 256, 512, 2048};
    int k;
    wr(OFS_CMP_A, 32'h1);
    wr(OFS_CTRL_A, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL_B, 32'(i + 2));
      rise(k);
      rise(k);
      rise(k);
      chk(32'(k), 32'(per[i]));
    end
    wr(OFS_CTRL_B, 32'h0);
    $display("test prescaler done");
  endtask : t_presc

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    osc_pin_in = 1'b0;
    int_ack = 3'h0;
    n_fail = 0;
    comparisons = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_stop();
    t_power();
    t_prio();
    t_modes();
    t_irq();
    t_async();
    t_presc();
    wrap_up();
  end

  initial begin
    #(25 * 40000);
    n_fail++;
    $display("[ERR] %0t watchdog got %h exp %h", $time, 32'h1, 32'h0);
    wrap_up();
  end
endmodule : tb

// ### tmr8_timer.sv
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tmr8_timer
  import tmr8_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic OSC_PIN_IN,
  input wire logic INT_ACK_OVF,
  input wire logic INT_ACK_CMPA,
  input wire logic INT_ACK_CMPB,
  output logic IRQ_OVF,
  output logic IRQ_CMPA,
  output logic IRQ_CMPB,
  output logic COUNT_AT_BOTTOM,
  output logic COUNT_AT_MAX,
  output logic COUNT_AT_TOP
);
  // bus slave
  tmr8_bus_t bus_st;
  tmr8_bus_t next_bus_st;
  logic [DATA_W-1:0] next_rdata;
  logic next_waitreq;
  logic acc_wr;
  logic [DATA_W-1:0] rd_mux;

  // software state
  logic [1:0] waveform_mode_low;
  logic waveform_mode_bit2;
  logic [2:0] clock_select_field;
  logic [CNT_W-1:0] count_value;
  logic [CNT_W-1:0] compare_value_a;
  logic [CNT_W-1:0] compare_value_b;
  logic [CNT_W-1:0] cmp_a_act;
  logic [CNT_W-1:0] cmp_b_act;
  logic [NFLAG-1:0] timer_flag_register;
  logic [NFLAG-1:0] timer_mask_register;
  logic async_clock_select;
  logic timer_power_reduce_bit;
  logic dir_up;
  logic [1:0] next_waveform_mode_low;
  logic next_waveform_mode_bit2;
  logic [2:0] next_clock_select_field;
  logic [CNT_W-1:0] next_count_value;
  logic [CNT_W-1:0] next_compare_value_a;
  logic [CNT_W-1:0] next_compare_value_b;
  logic [CNT_W-1:0] next_cmp_a_act;
  logic [CNT_W-1:0] next_cmp_b_act;
  logic [NFLAG-1:0] next_timer_flag_register;
  logic [NFLAG-1:0] next_timer_mask_register;
  logic next_async_clock_select;
  logic next_timer_power_reduce_bit;
  logic next_dir_up;

  // oscillator pin synchroniser and edge
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic src_tick;
  logic timer_tick_clock;

  logic [2:0] mode;
  logic pwm_mode;
  logic phase_mode;
  logic [CNT_W-1:0] top_value;
  logic cnt_wr;
  logic [NFLAG-1:0] flag_set;
  logic [NFLAG-1:0] flag_clr;
  logic [NFLAG-1:0] int_ack;

  assign int_ack = {INT_ACK_CMPB, INT_ACK_CMPA, INT_ACK_OVF};

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= OSC_PIN_IN;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // source is the I/O clock unless async select is set
  assign src_tick = async_clock_select ? (osc_s2 && !osc_s3) : 1'b1;

  tmr8_prescaler #(
    .W(PRE_W)
  ) u_pre (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .src_tick(src_tick),
    .enable(!timer_power_reduce_bit),
    .clk_sel(clock_select_field),
    .tick(timer_tick_clock)
  );

  // waveform mode field split over two control registers
  assign mode = {waveform_mode_bit2, waveform_mode_low};
  assign pwm_mode = mode[0];
  assign phase_mode = (mode == WGM_PC_MAX) || (mode == WGM_PC_CMP);
  // top from compare A or fixed maximum
  assign top_value = ((mode == WGM_CTC) || (mode == WGM_PC_CMP) || (mode == WGM_FAST_CMP))
                     ? cmp_a_act : CNT_MAX;

  assign acc_wr = AVS_WRITE && (bus_st == TMR8_BUS_ACK) && AVS_BYTEENABLE[0];
  assign cnt_wr = acc_wr && (AVS_ADDRESS == OFS_COUNT);

  always_comb begin
    rd_mux = '0;
    if (AVS_ADDRESS == OFS_CTRL_A) begin
      rd_mux[1:0] = waveform_mode_low;
    end else if (AVS_ADDRESS == OFS_CTRL_B) begin
      rd_mux[CTRLB_WGM2] = waveform_mode_bit2;
      rd_mux[2:0] = clock_select_field;
    end else if (AVS_ADDRESS == OFS_COUNT) begin
      rd_mux[CNT_W-1:0] = count_value;
    end else if (AVS_ADDRESS == OFS_CMP_A) begin
      rd_mux[CNT_W-1:0] = compare_value_a;
    end else if (AVS_ADDRESS == OFS_CMP_B) begin
      rd_mux[CNT_W-1:0] = compare_value_b;
    end else if (AVS_ADDRESS == OFS_FLAG) begin
      rd_mux[NFLAG-1:0] = timer_flag_register;
    end else if (AVS_ADDRESS == OFS_MASK) begin
      rd_mux[NFLAG-1:0] = timer_mask_register;
    end else if (AVS_ADDRESS == OFS_ASYNC) begin
      rd_mux[ASYNC_SEL_BIT] = async_clock_select;
    end else if (AVS_ADDRESS == OFS_POWER) begin
      rd_mux[POWER_BIT] = timer_power_reduce_bit;
    end
  end

  // one wait cycle, then the transfer completes
  always_comb begin
    next_bus_st = TMR8_BUS_IDLE;
    next_rdata = AVS_READDATA;
    next_waitreq = 1'b1;
    if ((bus_st == TMR8_BUS_IDLE) && (AVS_READ || AVS_WRITE)) begin
      next_bus_st = TMR8_BUS_ACK;
      next_waitreq = 1'b0;
      next_rdata = AVS_READ ? rd_mux : '0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_st <= TMR8_BUS_IDLE;
      AVS_READDATA <= '0;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      bus_st <= next_bus_st;
      AVS_READDATA <= next_rdata;
      AVS_WAITREQUEST <= next_waitreq;
    end
  end

  always_comb begin
    next_waveform_mode_low = waveform_mode_low;
    next_waveform_mode_bit2 = waveform_mode_bit2;
    next_clock_select_field = clock_select_field;
    next_count_value = count_value;
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_cmp_a_act = cmp_a_act;
    next_cmp_b_act = cmp_b_act;
    next_timer_mask_register = timer_mask_register;
    next_async_clock_select = async_clock_select;
    next_timer_power_reduce_bit = timer_power_reduce_bit;
    next_dir_up = dir_up;
    flag_set = '0;
    flag_clr = int_ack;
    // continuous compare, flag raised on the timer tick
    flag_set[FLG_CMPA] = timer_tick_clock && (count_value == cmp_a_act);
    flag_set[FLG_CMPB] = timer_tick_clock && (count_value == cmp_b_act);
    if (timer_tick_clock) begin
      // clear, increment or decrement per mode
      if (phase_mode) begin
        if (dir_up && (count_value == top_value)) begin
          next_dir_up = 1'b0;
          next_count_value = CNT_W'(count_value - CNT_ONE);
        end else if (!dir_up && (count_value == CNT_BOTTOM)) begin
          next_dir_up = 1'b1;
          next_count_value = CNT_W'(count_value + CNT_ONE);
        end else begin
          next_count_value = dir_up ? CNT_W'(count_value + CNT_ONE)
                                    : CNT_W'(count_value - CNT_ONE);
        end
        flag_set[FLG_OVF] = !dir_up && (count_value == CNT_ONE);
      end else begin
        next_dir_up = 1'b1;
        if ((mode == WGM_CTC) || (mode == WGM_FAST_MAX) || (mode == WGM_FAST_CMP)) begin
          next_count_value = (count_value == top_value) ? CNT_BOTTOM
                             : CNT_W'(count_value + CNT_ONE);
        end else begin
          next_count_value = CNT_W'(count_value + CNT_ONE);
        end
        if ((mode == WGM_FAST_MAX) || (mode == WGM_FAST_CMP)) begin
          flag_set[FLG_OVF] = (count_value == top_value);
        end else begin
          flag_set[FLG_OVF] = (count_value == CNT_MAX);
        end
      end
      // pwm modes reload compare copies at top
      if (pwm_mode && (count_value == top_value)) begin
        next_cmp_a_act = compare_value_a;
        next_cmp_b_act = compare_value_b;
      end
    end
    if (!pwm_mode) begin
      next_cmp_a_act = compare_value_a;
      next_cmp_b_act = compare_value_b;
    end
    if (acc_wr) begin
      if (AVS_ADDRESS == OFS_CTRL_A) begin
        next_waveform_mode_low = AVS_WRITEDATA[1:0];
      end else if (AVS_ADDRESS == OFS_CTRL_B) begin
        next_waveform_mode_bit2 = AVS_WRITEDATA[CTRLB_WGM2];
        next_clock_select_field = AVS_WRITEDATA[2:0];
      end else if (AVS_ADDRESS == OFS_COUNT) begin
        next_count_value = AVS_WRITEDATA[CNT_W-1:0];
      end else if (AVS_ADDRESS == OFS_CMP_A) begin
        next_compare_value_a = AVS_WRITEDATA[CNT_W-1:0];
      end else if (AVS_ADDRESS == OFS_CMP_B) begin
        next_compare_value_b = AVS_WRITEDATA[CNT_W-1:0];
      end else if (AVS_ADDRESS == OFS_FLAG) begin
        flag_clr = flag_clr | AVS_WRITEDATA[NFLAG-1:0];
      end else if (AVS_ADDRESS == OFS_MASK) begin
        next_timer_mask_register = AVS_WRITEDATA[NFLAG-1:0];
      end else if (AVS_ADDRESS == OFS_ASYNC) begin
        next_async_clock_select = AVS_WRITEDATA[ASYNC_SEL_BIT];
      end else if (AVS_ADDRESS == OFS_POWER) begin
        next_timer_power_reduce_bit = AVS_WRITEDATA[POWER_BIT];
      end
    end
    // a new event wins over a clear in the same cycle
    next_timer_flag_register = (timer_flag_register & ~flag_clr) | flag_set;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      waveform_mode_low <= 2'h0;
      waveform_mode_bit2 <= 1'b0;
      clock_select_field <= CS_STOP;
      count_value <= CNT_BOTTOM;
      compare_value_a <= CNT_BOTTOM;
      compare_value_b <= CNT_BOTTOM;
      cmp_a_act <= CNT_BOTTOM;
      cmp_b_act <= CNT_BOTTOM;
      timer_flag_register <= '0;
      timer_mask_register <= '0;
      async_clock_select <= 1'b0;
      timer_power_reduce_bit <= 1'b0;
      dir_up <= 1'b1;
      IRQ_OVF <= 1'b0;
      IRQ_CMPA <= 1'b0;
      IRQ_CMPB <= 1'b0;
      COUNT_AT_BOTTOM <= 1'b1;
      COUNT_AT_MAX <= 1'b0;
      COUNT_AT_TOP <= 1'b0;
    end else begin
      waveform_mode_low <= next_waveform_mode_low;
      waveform_mode_bit2 <= next_waveform_mode_bit2;
      clock_select_field <= next_clock_select_field;
      count_value <= next_count_value;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      cmp_a_act <= next_cmp_a_act;
      cmp_b_act <= next_cmp_b_act;
      timer_flag_register <= next_timer_flag_register;
      timer_mask_register <= next_timer_mask_register;
      async_clock_select <= next_async_clock_select;
      timer_power_reduce_bit <= next_timer_power_reduce_bit;
      dir_up <= next_dir_up;
      IRQ_OVF <= next_timer_flag_register[FLG_OVF] && next_timer_mask_register[FLG_OVF];
      IRQ_CMPA <= next_timer_flag_register[FLG_CMPA] && next_timer_mask_register[FLG_CMPA];
      IRQ_CMPB <= next_timer_flag_register[FLG_CMPB] && next_timer_mask_register[FLG_CMPB];
      COUNT_AT_BOTTOM <= (next_count_value == CNT_BOTTOM);
      COUNT_AT_MAX <= (next_count_value == CNT_MAX);
      COUNT_AT_TOP <= (next_count_value == top_value);
    end
  end

  // checks
  sequence s_bus_req;
    (AVS_READ || AVS_WRITE) && (bus_st == TMR8_BUS_IDLE);
  endsequence
  sequence s_bus_done;
    !AVS_WAITREQUEST;
  endsequence
  sequence s_phase_top;
    timer_tick_clock && phase_mode && dir_up && (count_value == top_value) && !cnt_wr;
  endsequence

  property p_bus_answer;
    @(posedge SYS_CLK) disable iff (!RST_N) s_bus_req |=> s_bus_done;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait");

  property p_power_stop;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (timer_power_reduce_bit && !cnt_wr) |=> (count_value == $past(count_value));
  endproperty
  a_power_stop: assert property (p_power_stop) else $error("count moved in power reduce");

  property p_cs_stop;
    @(posedge SYS_CLK) disable iff (!RST_N)
      ((clock_select_field == CS_STOP) && !cnt_wr) |=> (count_value == $past(count_value));
  endproperty
  a_cs_stop: assert property (p_cs_stop) else $error("count moved with no clock");

  property p_sw_wins;
    @(posedge SYS_CLK) disable iff (!RST_N)
      cnt_wr |=> (count_value == $past(AVS_WRITEDATA[CNT_W-1:0]));
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("count write lost");

  property p_direct_tick;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (!async_clock_select && !timer_power_reduce_bit && (clock_select_field == CS_DIRECT)
       && (mode == WGM_NORMAL) && !cnt_wr)
      |=> (count_value == CNT_W'($past(count_value) + CNT_ONE));
  endproperty
  a_direct_tick: assert property (p_direct_tick) else $error("io clock not ticking");

  property p_ovf_normal;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (timer_tick_clock && (mode == WGM_NORMAL) && (count_value == CNT_MAX) && !cnt_wr)
      |=> (count_value == CNT_BOTTOM) && timer_flag_register[FLG_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("normal wrap without overflow");

  property p_ctc_clear;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (timer_tick_clock && (mode == WGM_CTC) && (count_value == cmp_a_act) && !cnt_wr)
      |=> (count_value == CNT_BOTTOM) && timer_flag_register[FLG_CMPA];
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear on match");

  property p_fast_top;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (timer_tick_clock && (mode == WGM_FAST_MAX) && (count_value == CNT_MAX) && !cnt_wr)
      |=> (count_value == CNT_BOTTOM) && timer_flag_register[FLG_OVF];
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast pwm top wrong");

  property p_phase_turn;
    @(posedge SYS_CLK) disable iff (!RST_N)
      s_phase_top |=> !dir_up && (count_value == CNT_W'($past(count_value) - CNT_ONE));
  endproperty
  a_phase_turn: assert property (p_phase_turn) else $error("phase mode did not turn");

  property p_cmp_b;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (timer_tick_clock && (count_value == cmp_b_act)) |=> timer_flag_register[FLG_CMPB];
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare b flag missed");

  property p_irq_gate;
    @(posedge SYS_CLK) disable iff (!RST_N)
      IRQ_CMPA == (timer_flag_register[FLG_CMPA] && timer_mask_register[FLG_CMPA]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request not flag and mask");

  property p_max_ind;
    @(posedge SYS_CLK) disable iff (!RST_N) COUNT_AT_MAX == (count_value == CNT_MAX);
  endproperty
  a_max_ind: assert property (p_max_ind) else $error("max indication wrong");
endmodule : tmr8_timer
